// ---- include/ssl_pkg.sv ----
// constants and types shared by the speed scaling linearizer
package ssl_pkg;

  // ----------------------------------------------------------------
  // clock and time base
  // ----------------------------------------------------------------
  localparam int CLK_NS        = 50;          // 20 MHz pclk
  localparam int MS_NS         = 1_000_000;   // one millisecond
  localparam int MS_CYCLES_DEF = MS_NS / CLK_NS;
  localparam int CS_TO_MS      = 10;          // setting unit 0.01 s

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int PT_W   = 18;                 // milli-percent, signed
  localparam int NUM_W  = 52;                 // divider dividend
  localparam int DEN_W  = 32;                 // divider divisor
  localparam int CNT_W  = 6;                  // divider step count
  localparam int TMR_W  = 20;                 // ms since last pulse
  localparam int NPTS   = 16;                 // interpolation pairs

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL    = 12'h000;
  localparam logic [11:0] OFS_PPR     = 12'h004;
  localparam logic [11:0] OFS_MULT    = 12'h008;
  localparam logic [11:0] OFS_REFRESH = 12'h00C;
  localparam logic [11:0] OFS_WAIT    = 12'h010;
  localparam logic [11:0] OFS_STILL   = 12'h014;
  localparam logic [11:0] OFS_STATUS  = 12'h018;
  localparam logic [11:0] OFS_DISPLAY = 12'h01C;
  localparam logic [11:0] OFS_COMPARE = 12'h020;
  localparam logic [11:0] OFS_LINOUT  = 12'h024;
  localparam logic [11:0] OFS_PT_LO   = 12'h040;  // x at +8i, y at +8i+4
  localparam logic [11:0] OFS_PT_HI   = 12'h0BC;

  // ----------------------------------------------------------------
  // field positions in the control register
  // ----------------------------------------------------------------
  localparam int CTRL_UNIT_LSB = 0;           // [2:0] unit code
  localparam int CTRL_LIN_LSB  = 4;           // [5:4] curve mode

  // ----------------------------------------------------------------
  // reset values and legal ranges
  // ----------------------------------------------------------------
  localparam logic [2:0]      UNIT_RST    = 3'h0;
  localparam logic [2:0]      UNIT_MAX    = 3'h4;
  localparam logic [1:0]      LIN_RST     = 2'h0;
  localparam logic [16:0]     PPR_RST     = 17'h0_0001;
  localparam logic [16:0]     PPR_MAX     = 17'h1_869F;  // 99999
  localparam logic [7:0]      MULT_RST    = 8'h01;
  localparam logic [7:0]      MULT_MAX    = 8'hC8;       // 200
  localparam logic [9:0]      REFR_RST    = 10'h064;     // 100 ms
  localparam logic [9:0]      REFR_MIN    = 10'h032;     // 50 ms
  localparam logic [9:0]      REFR_MAX    = 10'h3E8;     // 1000 ms
  localparam logic [13:0]     WAIT_RST    = 14'h01F4;    // 5.00 s
  localparam logic [13:0]     STILL_RST   = 14'h0000;
  localparam logic [13:0]     TIME_MAX    = 14'h270F;    // 99.99 s
  localparam logic signed [PT_W-1:0] PT_RST = 18'sh1_86A0; // 100.000
  localparam logic signed [PT_W-1:0] PT_MAX = 18'sh1_86A0;
  localparam logic signed [PT_W-1:0] PT_MIN = -18'sh1_86A0;

  // ----------------------------------------------------------------
  // unit codes, curve modes and scale factors (milli units)
  // ----------------------------------------------------------------
  localparam logic [2:0]  UNIT_HZ     = 3'h0;
  localparam logic [2:0]  UNIT_KHZ    = 3'h1;
  localparam logic [2:0]  UNIT_RPS    = 3'h2;
  localparam logic [2:0]  UNIT_RPM    = 3'h3;
  localparam logic [2:0]  UNIT_CUSTOM = 3'h4;
  localparam logic [1:0]  LIN_OFF     = 2'h0;
  localparam logic [1:0]  LIN_MIRROR  = 2'h1;
  localparam logic [1:0]  LIN_DIRECT  = 2'h2;
  localparam logic [17:0] K_ONE       = 18'h0_0001;
  localparam logic [17:0] K_MILLI     = 18'h0_03E8;   // 1000
  localparam logic [17:0] K_RPM       = 18'h0_EA60;   // 60 x 1000

  typedef enum logic [1:0] {
    SSL_IDLE,
    SSL_SCALE,
    SSL_LIN
  } ssl_phase_t;

endpackage

// ---- verilog/ssl_linearizer.sv ----
// speed scaling, display refresh, zero detect and curve linearizer
`timescale 1ns/1ns
module ssl_linearizer
  import ssl_pkg::*;
#(
  parameter int FREQ_W    = 32,
  parameter int MS_CYCLES = MS_CYCLES_DEF
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   ce,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output      logic [31:0]            prdata,
  output      logic                   pready,
  output      logic                   pslverr,
  input  wire logic [FREQ_W-1:0]      freq_hz,
  input  wire logic                   pulse_seen,
  input  wire logic signed [PT_W-1:0] lin_in,
  output      logic [31:0]            display_value,
  output      logic [31:0]            compare_value,
  output      logic signed [PT_W-1:0] lin_out,
  output      logic                   display_strobe,
  output      logic                   zero_freq,
  output      logic                   standstill
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0]                 prdata;
    logic                        pready;
    logic                        pslverr;
    logic [2:0]                  unit_code;
    logic [1:0]                  lin_mode;
    logic [16:0]                 ppr;
    logic [7:0]                  mult;
    logic [9:0]                  refresh_ms;
    logic [13:0]                 wait_cs;
    logic [13:0]                 still_cs;
    logic [NPTS-1:0][PT_W-1:0]   px;
    logic [NPTS-1:0][PT_W-1:0]   py;
    logic [15:0]                 ms_div;
    logic [9:0]                  ref_cnt;
    logic [TMR_W-1:0]            since_ms;
    ssl_phase_t                  phase;
    logic [FREQ_W-1:0]           f_lat;
    logic signed [PT_W-1:0]      x_lat;
    logic [NUM_W-1:0]            dnum;
    logic [DEN_W-1:0]            drem;
    logic [DEN_W-1:0]            dden;
    logic [CNT_W-1:0]            dcnt;
    logic signed [PT_W:0]        lin_base;
    logic                        lin_neg;
    logic                        lin_flip;
    logic [31:0]                 display_value;
    logic [31:0]                 compare_value;
    logic signed [PT_W-1:0]      lin_out;
    logic                        display_strobe;
    logic                        zero_freq;
    logic                        standstill;
  } ssl_state_t;

  ssl_state_t s;
  ssl_state_t next_s;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // clamp an unsigned setting into its legal range
  function automatic logic [31:0] clampu(input logic [31:0] v,
                                         input logic [31:0] lo,
                                         input logic [31:0] hi);
    return (v < lo) ? lo : (v > hi) ? hi : v;
  endfunction
  // clamp a written coordinate to +-100.000 percent
  function automatic logic [PT_W-1:0] clamp_pt(input logic [31:0] v);
    logic signed [31:0] sv;
    sv = $signed(v);
    return (sv > 32'(PT_MAX)) ? PT_MAX :
           (sv < 32'(PT_MIN)) ? PT_MIN : sv[PT_W-1:0];
  endfunction

  // saturate a wide quotient or product into 32 bits
  function automatic logic [31:0] sat32(input logic [NUM_W-1:0] v);
    return (v[NUM_W-1:32] != '0) ? 32'hFFFF_FFFF : v[31:0];
  endfunction

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  logic [31:0]             rd;
  logic                    hit;
  logic [3:0]              pi;
  logic                    ms_tick;
  logic                    start;
  logic [FREQ_W-1:0]       f_eff;
  logic [17:0]             k;
  logic [32:0]             rsh;
  logic                    qbit;
  logic signed [PT_W:0]    v;
  logic [3:0]              seg;
  logic signed [PT_W:0]    dx;
  logic signed [PT_W:0]    dy;
  logic signed [PT_W:0]    dxd;
  logic [37:0]             prod;
  logic signed [PT_W+1:0]  yres;
  logic [TMR_W-1:0]        zero_lim;
  logic [TMR_W-1:0]        still_lim;

  always_comb begin
    next_s = s;
    rd = '0;
    hit = 1'b1;
    pi = 4'((paddr - OFS_PT_LO) >> 3);                // point index 0..15
    ms_tick = 1'b0;
    start = 1'b0;
    f_eff = '0;
    k = K_ONE;
    rsh = '0;
    qbit = 1'b0;
    v = '0;
    seg = '0;
    dx = '0;
    dy = '0;
    dxd = '0;
    prod = '0;
    yres = '0;
    zero_lim = TMR_W'(s.wait_cs * CS_TO_MS);
    still_lim = TMR_W'((s.wait_cs + s.still_cs) * CS_TO_MS);
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    next_s.display_strobe = 1'b0;
    // apb read decode in the setup cycle, answer in the access cycle
    if (paddr[1:0] != 2'h0) begin
      hit = 1'b0;
    end else if (paddr == OFS_CTRL) begin
      rd = 32'({s.lin_mode, 1'b0, s.unit_code});
    end else if (paddr == OFS_PPR) begin
      rd = 32'(s.ppr);
    end else if (paddr == OFS_MULT) begin
      rd = 32'(s.mult);
    end else if (paddr == OFS_REFRESH) begin
      rd = 32'(s.refresh_ms);
    end else if (paddr == OFS_WAIT) begin
      rd = 32'(s.wait_cs);
    end else if (paddr == OFS_STILL) begin
      rd = 32'(s.still_cs);
    end else if (paddr == OFS_STATUS) begin
      rd = 32'({s.phase != SSL_IDLE, s.standstill, s.zero_freq});
    end else if (paddr == OFS_DISPLAY) begin
      rd = s.display_value;
    end else if (paddr == OFS_COMPARE) begin
      rd = s.compare_value;
    end else if (paddr == OFS_LINOUT) begin
      rd = 32'(s.lin_out);
    end else if (paddr >= OFS_PT_LO && paddr <= OFS_PT_HI) begin
      rd = paddr[2] ? 32'($signed(s.py[pi])) : 32'($signed(s.px[pi]));
    end else begin
      hit = 1'b0;
    end
    if (psel && !penable) begin
      next_s.pready = 1'b1;
      next_s.pslverr = !hit;
      next_s.prdata = hit && !pwrite ? rd : 32'h0000_0000;
    end
    // apb write at the access edge; settings clamped into range
    if (psel && penable && s.pready && pwrite && !s.pslverr) begin
      if (paddr == OFS_CTRL) begin
        next_s.unit_code = 3'(clampu(32'(pwdata[CTRL_UNIT_LSB +: 3]),
                                     32'h0, 32'(UNIT_MAX)));
        next_s.lin_mode = pwdata[CTRL_LIN_LSB +: 2] == 2'h3 ?
                          LIN_DIRECT : pwdata[CTRL_LIN_LSB +: 2];
      end else if (paddr == OFS_PPR) begin
        next_s.ppr = 17'(clampu(pwdata, 32'h1, 32'(PPR_MAX)));
      end else if (paddr == OFS_MULT) begin
        next_s.mult = 8'(clampu(pwdata, 32'h1, 32'(MULT_MAX)));
      end else if (paddr == OFS_REFRESH) begin
        next_s.refresh_ms = 10'(clampu(pwdata, 32'(REFR_MIN),
                                       32'(REFR_MAX)));
      end else if (paddr == OFS_WAIT) begin
        next_s.wait_cs = 14'(clampu(pwdata, 32'h0, 32'(TIME_MAX)));
      end else if (paddr == OFS_STILL) begin
        next_s.still_cs = 14'(clampu(pwdata, 32'h0, 32'(TIME_MAX)));
      end else if (paddr >= OFS_PT_LO && paddr <= OFS_PT_HI) begin
        if (paddr[2]) begin
          next_s.py[pi] = clamp_pt(pwdata);
        end else begin
          next_s.px[pi] = clamp_pt(pwdata);
        end
      end
    end
    // millisecond time base
    if (32'(s.ms_div) >= 32'(MS_CYCLES - 1)) begin
      next_s.ms_div = '0;
      ms_tick = 1'b1;
    end else begin
      next_s.ms_div = s.ms_div + 16'h0001;
    end
    // pulse timeout: zero frequency after wait_cs, standstill after wait_cs plus still_cs
    if (pulse_seen) begin
      next_s.since_ms = '0;
    end else if (ms_tick && s.since_ms != '1) begin
      next_s.since_ms = s.since_ms + 1'b1;
    end
    next_s.zero_freq = !pulse_seen && s.since_ms >= zero_lim;
    next_s.standstill = !pulse_seen && s.since_ms >= still_lim;
    // refresh period counter
    if (ms_tick) begin
      if (s.ref_cnt + 10'h001 >= s.refresh_ms) begin
        next_s.ref_cnt = '0;
        start = 1'b1;
      end else begin
        next_s.ref_cnt = s.ref_cnt + 10'h001;
      end
    end
    // scale factor per unit code, result kept in thousandths
    f_eff = s.zero_freq ? '0 : freq_hz;
    case (s.unit_code)
      UNIT_HZ:     k = K_MILLI;
      UNIT_KHZ:    k = K_ONE;
      UNIT_RPS:    k = K_MILLI;
      UNIT_RPM:    k = K_RPM;
      UNIT_CUSTOM: k = 18'(s.mult * K_MILLI);
      default:     k = K_MILLI;
    endcase
    // one restoring divider step, shared by both phases
    rsh = {s.drem, s.dnum[NUM_W-1]};
    if (rsh >= {1'b0, s.dden}) begin
      rsh = rsh - {1'b0, s.dden};
      qbit = 1'b1;
    end
    // curve segment search on the latched input
    v = (s.lin_mode == LIN_MIRROR && s.x_lat < 0) ?
        -(PT_W+1)'(s.x_lat) : (PT_W+1)'(s.x_lat);
    for (int i = 0; i < NPTS - 1; i++) begin
      if (v >= $signed(s.px[i])) begin
        seg = 4'(i);
      end
    end
    dx = v - $signed(s.px[seg]);
    dy = $signed(s.py[seg + 4'h1]) - $signed(s.py[seg]);
    dxd = $signed(s.px[seg + 4'h1]) - $signed(s.px[seg]);
    prod = 38'(dx) * 38'(dy < 0 ? -dy : dy);
    // measurement sequence
    case (s.phase)
      SSL_IDLE: begin
        if (start) begin
          next_s.phase = SSL_SCALE;
          next_s.f_lat = f_eff;
          next_s.x_lat = lin_in;
          next_s.dnum = NUM_W'(f_eff) * NUM_W'(k);  // full-width product
          next_s.dden = (s.unit_code >= UNIT_RPS) ?
                        DEN_W'(s.ppr) : DEN_W'(1);
          next_s.drem = '0;
          next_s.dcnt = CNT_W'(NUM_W);
        end
      end
      SSL_SCALE: begin
        if (s.dcnt != '0) begin
          next_s.drem = rsh[DEN_W-1:0];
          next_s.dnum = {s.dnum[NUM_W-2:0], qbit};
          next_s.dcnt = s.dcnt - 1'b1;
        end else begin
          next_s.display_value = sat32(s.dnum);
          next_s.compare_value = (s.unit_code >= UNIT_RPS) ?
                                 sat32(s.dnum) :
                                 sat32(NUM_W'(s.f_lat) * K_MILLI);
          next_s.phase = SSL_LIN;
          next_s.lin_flip = s.lin_mode == LIN_MIRROR && s.x_lat < 0;
          next_s.lin_neg = dy < 0;
          next_s.lin_base = $signed(s.py[seg]);
          next_s.dnum = NUM_W'(prod);
          next_s.dden = DEN_W'(dxd);
          next_s.drem = '0;
          next_s.dcnt = CNT_W'(NUM_W);
          if (s.lin_mode == LIN_OFF) begin
            next_s.lin_base = (PT_W+1)'(s.x_lat);
            next_s.dnum = '0;
            next_s.dcnt = '0;
          end else if (v <= $signed(s.px[0])) begin
            next_s.lin_base = $signed(s.py[0]);
            next_s.dnum = '0;
            next_s.dcnt = '0;
          end else if (v >= $signed(s.px[NPTS-1]) || dxd <= 0) begin
            next_s.lin_base = v >= $signed(s.px[NPTS-1]) ?
                              $signed(s.py[NPTS-1]) : $signed(s.py[seg]);
            next_s.dnum = '0;
            next_s.dcnt = '0;
          end
        end
      end
      SSL_LIN: begin
        if (s.dcnt != '0) begin
          next_s.drem = rsh[DEN_W-1:0];
          next_s.dnum = {s.dnum[NUM_W-2:0], qbit};
          next_s.dcnt = s.dcnt - 1'b1;
        end else begin
          yres = s.lin_neg ? (PT_W+2)'(s.lin_base) - (PT_W+2)'(s.dnum)
                           : (PT_W+2)'(s.lin_base) + (PT_W+2)'(s.dnum);
          if (s.lin_flip) begin
            yres = -yres;
          end
          next_s.lin_out = yres[PT_W-1:0];
          next_s.display_strobe = 1'b1;
          next_s.phase = SSL_IDLE;
        end
      end
      default: begin
        next_s.phase = SSL_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register, frozen while ce is low
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.unit_code <= UNIT_RST;
      s.lin_mode <= LIN_RST;
      s.ppr <= PPR_RST;
      s.mult <= MULT_RST;
      s.refresh_ms <= REFR_RST;
      s.wait_cs <= WAIT_RST;
      s.still_cs <= STILL_RST;
      s.px <= {NPTS{PT_RST}};
      s.py <= {NPTS{PT_RST}};
      s.phase <= SSL_IDLE;
    end else if (ce) begin
      s <= next_s;
    end
  end
  // outputs straight from the state flops
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign display_value = s.display_value;
  assign compare_value = s.compare_value;
  assign lin_out = s.lin_out;
  assign display_strobe = s.display_strobe;
  assign zero_freq = s.zero_freq;
  assign standstill = s.standstill;

endmodule // ssl_linearizer

// ---- tb/ssl_monitor.sv ----
// concurrent checks on the speed scaling linearizer ports
`timescale 1ns/1ns
module ssl_monitor
  import ssl_pkg::*;
(
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   ce,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   pulse_seen,
  input wire logic [31:0]            display_value,
  input wire logic signed [PT_W-1:0] lin_out,
  input wire logic                   display_strobe,
  input wire logic                   zero_freq,
  input wire logic                   standstill
);
  // ----------------------------------------------------------------
  // clocking and the steps the properties are built from
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence apb_setup;
    psel && !penable && ce;
  endsequence
  sequence pulse_in;
    pulse_seen && ce;
  endsequence

  // bus answer timing
  chk_ready_after_setup: assert property (apb_setup |=> pready)
    else $error("no ready in the access cycle");
  chk_ready_one_cycle: assert property (pready && ce |=> !pready)
    else $error("ready held past one cycle");
  chk_error_no_data: assert property (
    pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error answer without ready or with data");
  // latched results
  chk_strobe_spacing: assert property (
    display_strobe |=> !display_strobe [*8])
    else $error("refresh strobes too close");
  chk_display_held: assert property (
    $changed(display_value) |-> ##[0:60] display_strobe)
    else $error("display changed outside a refresh");
  chk_curve_held: assert property (
    $changed(lin_out) |-> display_strobe)
    else $error("curve output changed without strobe");
  // zero and standstill detection
  chk_still_after_zero: assert property (standstill |-> zero_freq)
    else $error("standstill without zero frequency");
  chk_pulse_clears: assert property (
    pulse_in |=> !zero_freq && !standstill)
    else $error("pulse did not clear zero flags");
endmodule // ssl_monitor

bind ssl_linearizer ssl_monitor mon (.pclk(pclk), .presetn(presetn), .ce(ce),
  .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pulse_seen(pulse_seen), .display_value(display_value),
  .lin_out(lin_out), .display_strobe(display_strobe),
  .zero_freq(zero_freq), .standstill(standstill));

// ---- tb/ssl_meas_model.sv ----
// pulse source standing in for the frequency measurement logic
`timescale 1ns/1ns
module ssl_meas_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic run,
  output      logic pulse_seen
);
  logic [1:0] div;

  // one-cycle pulse every fourth cycle while running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div        <= 2'h0;
      pulse_seen <= 1'b0;
    end else begin
      div        <= div + 2'h1;
      pulse_seen <= run && div == 2'h3;
    end
  end
endmodule // ssl_meas_model

// ---- tb/test_speed_scaling_linearizer.sv ----
// self-checking bench for the speed scaling linearizer
`timescale 1ns/1ns
module test_speed_scaling_linearizer;
  import ssl_pkg::*;
  localparam int MS = 20;
  logic                   pclk, presetn, ce, psel, penable, pwrite;
  logic                   pready, pslverr, pulse_seen, run, err;
  logic                   display_strobe, zero_freq, standstill;
  logic [11:0]            paddr;
  logic [31:0]            pwdata, prdata, rd, freq_hz;
  logic [31:0]            display_value, compare_value;
  logic signed [PT_W-1:0] lin_in, lin_out;
  int                     errors, tests_run;

  // ----------------------------------------------------------------
  // design, pulse source and clock
  // ----------------------------------------------------------------
  ssl_linearizer #(.MS_CYCLES(MS)) dut (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .freq_hz(freq_hz), .pulse_seen(pulse_seen), .lin_in(lin_in),
    .display_value(display_value), .compare_value(compare_value),
    .lin_out(lin_out), .display_strobe(display_strobe),
    .zero_freq(zero_freq), .standstill(standstill));
  ssl_meas_model model (.pclk(pclk), .presetn(presetn), .run(run),
    .pulse_seen(pulse_seen));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, held until ready is sampled at a rising edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      errors++;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask
  // cycles until the next refresh strobe
  task wait_strobe(output int n);
    n = 0;
    do begin @(negedge pclk); n++; end
    while (display_strobe !== 1'b1 && n < 1200);
    if (display_strobe !== 1'b1) begin
      errors++;
    end
  endtask
  task give_verdict;
    if (errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task test_defaults;
    rdchk(OFS_CTRL, 32'h0000_0000);
    rdchk(OFS_PPR, 32'h0000_0001);
    rdchk(OFS_MULT, 32'h0000_0001);
    rdchk(OFS_REFRESH, 32'h0000_0064);
    rdchk(OFS_WAIT, 32'h0000_01F4);
    rdchk(OFS_PT_LO, 32'h0001_86A0);
    rdchk(OFS_PT_HI, 32'h0001_86A0);
    apb(1'b0, 12'h030, 32'h0000_0000);
    check({31'h0000_0000, err}, 32'h0000_0001);
    apb(1'b1, OFS_REFRESH, 32'h0000_000A);
    rdchk(OFS_REFRESH, 32'h0000_0032);
  endtask
  task test_units;
    logic [31:0] dsp [5];
    int          n;
    dsp = '{32'h000F_4240, 32'h0000_03E8, 32'h0003_D090, 32'h00E4_E1C0,
            32'h000B_71B0};
    apb(1'b1, OFS_PPR, 32'h0000_0004);
    apb(1'b1, OFS_MULT, 32'h0000_0003);
    for (int c = 0; c < 5; c++) begin
      apb(1'b1, OFS_CTRL, 32'(c));
      wait_strobe(n);
      wait_strobe(n);
      check(display_value, dsp[c]);
      check(compare_value, (c < 2) ? 32'h000F_4240 : dsp[c]);
      check(32'(n), 32'h0000_03E8);
    end
  endtask
  task test_curve;
    logic [17:0] li [3];
    logic [1:0]  md [3];
    logic [31:0] x0 [3];
    logic [31:0] ex [3];
    logic [31:0] xv;
    int          n;
    li = '{18'h3_3CB0, 18'h0_C350, 18'h3_3CB0};
    md = '{2'h1, 2'h2, 2'h2};
    x0 = '{32'h0000_0000, 32'hFFFE_7960, 32'hFFFE_7960};
    ex = '{32'hFFFE_FC31, 32'h0001_4A24, 32'h0000_A221};
    // x rises strictly from 86.000 at point 2 to 100.000 at point 16
    for (int i = 1; i < NPTS; i++) begin
      xv = 32'h0001_86A0 - 32'(NPTS - 1 - i) * 32'h0000_03E8;
      apb(1'b1, OFS_PT_LO + 12'(i) * 12'h008, xv);
    end
    apb(1'b1, OFS_PT_LO + 12'h004, 32'h0000_4E20);
    for (int k = 0; k < 3; k++) begin
      @(posedge pclk);
      lin_in <= li[k];
      apb(1'b1, OFS_PT_LO, x0[k]);
      apb(1'b1, OFS_CTRL, {26'h000_0000, md[k], 4'h0});
      wait_strobe(n);
      wait_strobe(n);
      check({{14{lin_out[17]}}, lin_out}, ex[k]);
    end
  endtask
  task test_zero;
    int n;
    apb(1'b1, OFS_WAIT, 32'h0000_0001);
    apb(1'b1, OFS_STILL, 32'h0000_0001);
    @(posedge pclk);
    run <= 1'b0;
    repeat (170) @(negedge pclk);
    check({31'h0000_0000, zero_freq}, 32'h0000_0000);
    repeat (50) @(negedge pclk);
    check({30'h0000_0000, standstill, zero_freq}, 32'h0000_0001);
    repeat (130) @(negedge pclk);
    check({31'h0000_0000, standstill}, 32'h0000_0000);
    repeat (70) @(negedge pclk);
    check({31'h0000_0000, standstill}, 32'h0000_0001);
    wait_strobe(n);
    wait_strobe(n);
    check(display_value, 32'h0000_0000);
    @(posedge pclk);
    run <= 1'b1;
    repeat (20) @(negedge pclk);
    check({31'h0000_0000, zero_freq}, 32'h0000_0000);
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    errors = 0;
    tests_run = 0;
    presetn = 1'b0;
    ce = 1'b1;
    run = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    freq_hz = 32'h0000_03E8;
    lin_in = 18'h0_0000;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    test_defaults;
    test_units;
    test_curve;
    test_zero;
    give_verdict;
  end
  initial begin
    repeat (60000) @(posedge pclk);
    errors++;
    give_verdict;
  end
endmodule // test_speed_scaling_linearizer
